// ==== hdl/capb_consts.svh ====
`ifndef CAPB_CONSTS_SVH
`define CAPB_CONSTS_SVH

// ========
// register offsets
`define CAPB_A_BTN_CFG 8'h21
`define CAPB_A_AVG_LVL 8'h22
`define CAPB_A_NEG_LVL 8'h23
`define CAPB_A_NEG_MAX 8'h24
`define CAPB_A_HYST 8'h25
`define CAPB_A_STUCK 8'h26
`define CAPB_A_WAKE_LEN 8'h33
`define CAPB_A_KEYS_54 8'h34
`define CAPB_A_KEYS_32 8'h35
`define CAPB_A_KEYS_10 8'h36

// ========
// reset values
`define CAPB_R_BTN_CFG 8'h30
`define CAPB_R_AVG_LVL 8'h50
`define CAPB_R_NEG_LVL 8'h50
`define CAPB_R_NEG_MAX 8'h01
`define CAPB_R_HYST 8'h0a
`define CAPB_R_STUCK 8'h00
`define CAPB_R_WAKE_LEN 3'h0
`define CAPB_R_KEYS 8'h00

// ========
// field positions and codes
`define CAPB_F_TDB 0
`define CAPB_F_RDB 2
`define CAPB_F_IRQ 4
`define CAPB_F_RPT 6
`define CAPB_IRQ_TOUCH 0
`define CAPB_IRQ_RELEASE 1
`define CAPB_RPT_FIRST 2'h1
`define CAPB_WAKE_ANY 3'h0
`define CAPB_WAKE_NONE 3'h7
`define CAPB_WAKE_LEN_W 3

// ========
// scaling and timing
`define CAPB_NSENS 8
`define CAPB_TW 16
`define CAPB_LVL_SHIFT 2
`define CAPB_PCT_FULL 8'h64
`define CAPB_DB_BASE 3'h1
`define CAPB_AVG_SHIFT 3
`define CAPB_COMP_SENSORS 4'h3
`define CAPB_CLK_HZ 200000000
`define CAPB_SECOND_S 1

`endif

// ==== hdl/capb_pkg.sv ====
package capb_pkg;
  typedef logic signed [15:0] capb_tick_t;
  typedef enum logic {CAPB_ACTIVE, CAPB_DOZE} capb_mode_t;
  typedef enum logic {CAPB_KEY_WAIT, CAPB_KEY_HELD} capb_wake_t;
endpackage

// ==== hdl/capb_cfg_if.sv ====
`timescale 1ns/1ps
interface capb_cfg_if;
  logic sample_valid;
  logic sec_tick;
  logic comp_clear;
  logic [1:0] touch_db;
  logic [1:0] release_db;
  logic [7:0] avg_level;
  logic [7:0] neg_level;
  logic [7:0] neg_limit;
  logic [7:0] hyst_pct;
  logic [7:0] stuck_secs;
  modport ctrl (output sample_valid, sec_tick, comp_clear, touch_db,
    release_db, avg_level, neg_level, neg_limit, hyst_pct, stuck_secs);
  modport chan (input sample_valid, sec_tick, comp_clear, touch_db,
    release_db, avg_level, neg_level, neg_limit, hyst_pct, stuck_secs);
endinterface

// ==== hdl/capb_chan.sv ====
`timescale 1ns/1ps
`include "capb_consts.svh"
module capb_chan
  import capb_pkg::*;
(
  input logic clk, // system clock
  input logic resetn, // async reset, low
  capb_cfg_if.chan cfg, // shared settings
  input capb_tick_t ticks, // sample of this sensor
  input logic [7:0] level, // sensor threshold code
  output logic touch_evt, // touch decided
  output logic release_evt, // release decided
  output logic touched, // current decision
  output logic frozen, // averaging suspended
  output logic neg_trig, // negative count hit
  output logic stuck_trig // held timeout hit
);
  logic signed [24:0] tick_w, thr_w, k100, pct_w, on_lvl, off_lvl;
  logic signed [24:0] neg_w;
  logic signed [16:0] diff;
  logic signed [15:0] avg, freeze_lvl;
  logic [2:0] cnt, next_cnt, need;
  logic [7:0] ncnt, next_ncnt, secs;
  logic above, below, pending, decide, stuck, stuck_hit, neg_below;

  // ========
  // threshold levels, all scaled by 100
  assign tick_w = 25'(ticks);
  assign thr_w = 25'({level, {`CAPB_LVL_SHIFT{1'b0}}});
  assign k100 = 25'(`CAPB_PCT_FULL);
  // above full scale the lower level would go negative, so clamp
  assign pct_w = (cfg.hyst_pct > `CAPB_PCT_FULL) ? k100 :
    25'(cfg.hyst_pct);
  assign on_lvl = 25'(thr_w * (k100 + pct_w));
  assign off_lvl = 25'(thr_w * (k100 - pct_w));
  assign above = 25'(tick_w * k100) > on_lvl;
  assign below = 25'(tick_w * k100) < off_lvl;

  // debounce decision
  assign need = touched ? 3'(cfg.release_db) + `CAPB_DB_BASE :
    3'(cfg.touch_db) + `CAPB_DB_BASE;
  assign pending = touched ? below : (above && !stuck);
  assign next_cnt = 3'(cnt + 3'h1);
  assign decide = pending && (next_cnt >= need);
  assign stuck_hit = touched && (cfg.stuck_secs != 8'h00) && cfg.sec_tick
    && (8'(secs + 8'h01) >= cfg.stuck_secs);

  // decision state; a stuck timeout outranks the sample
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      touched <= 1'b0;
      touch_evt <= 1'b0;
      release_evt <= 1'b0;
      cnt <= 3'h0;
      stuck <= 1'b0;
      stuck_trig <= 1'b0;
    end
    else
    begin
      touch_evt <= 1'b0;
      release_evt <= 1'b0;
      stuck_trig <= stuck_hit;
      if (stuck_hit)
      begin
        touched <= 1'b0;
        release_evt <= 1'b1;
        stuck <= 1'b1;
        cnt <= 3'h0;
      end
      else if (cfg.sample_valid)
      begin
        if (decide)
        begin
          touched <= !touched;
          touch_evt <= !touched;
          release_evt <= touched;
          cnt <= 3'h0;
        end
        else if (pending)
          cnt <= next_cnt;
        else
          cnt <= 3'h0;
        if (stuck && below)
          stuck <= 1'b0;
      end
    end
  end

  // seconds held; cleared whenever released
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      secs <= 8'h00;
    else if (!touched || stuck_hit)
      secs <= 8'h00;
    else if (cfg.sec_tick && secs != 8'hff)
      secs <= 8'(secs + 8'h01);
  end

  // ========
  // average, frozen once it reaches the level
  assign freeze_lvl = 16'({cfg.avg_level, {`CAPB_LVL_SHIFT{1'b0}}});
  assign frozen = avg >= freeze_lvl;
  assign diff = 17'(ticks) - 17'(avg);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      avg <= 16'h0000;
    else if (cfg.comp_clear)
      avg <= 16'h0000;
    else if (cfg.sample_valid && !frozen)
      avg <= 16'(avg + 16'(diff >>> `CAPB_AVG_SHIFT));
  end

  // negative tick counter
  assign neg_w = 25'({cfg.neg_level, {`CAPB_LVL_SHIFT{1'b0}}});
  assign neg_below = tick_w < -neg_w;
  assign next_ncnt = (ncnt == 8'hff) ? ncnt : 8'(ncnt + 8'h01);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ncnt <= 8'h00;
      neg_trig <= 1'b0;
    end
    else
    begin
      neg_trig <= 1'b0;
      if (cfg.comp_clear)
        ncnt <= 8'h00;
      else if (cfg.sample_valid)
      begin
        ncnt <= neg_below ? next_ncnt : 8'h00;
        neg_trig <= neg_below && (next_ncnt >= cfg.neg_limit);
      end
    end
  end
endmodule

// ==== hdl/capb_wake.sv ====
`timescale 1ns/1ps
`include "capb_consts.svh"
module capb_wake
  import capb_pkg::*;
(
  input logic clk, // system clock
  input logic resetn, // async reset, low
  input logic arm, // device dozing
  input logic [2:0] len, // sequence length
  input logic [23:0] keys, // key0 in low nibble
  input logic [7:0] touch_evt, // raw touches
  input logic [7:0] release_evt, // raw releases
  output logic wake // sequence done
);
  capb_wake_t st;
  logic [2:0] idx;
  logic [3:0] key;
  logic [7:0] key_bit;
  logic key_ok, hit, lifted, last;

  // ========
  // expected key of this step
  assign key = keys[5'({idx, 2'b00}) +: 4];
  assign key_ok = !key[3];
  assign key_bit = key_ok ? 8'(8'h01 << key[2:0]) : 8'h00;
  assign hit = (touch_evt & key_bit) != 8'h00;
  assign lifted = (release_evt & key_bit) != 8'h00;
  assign last = 3'(idx + 3'h1) == len;

  // step through keys; each needs its release
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= CAPB_KEY_WAIT;
      idx <= 3'h0;
      wake <= 1'b0;
    end
    else
    begin
      wake <= 1'b0;
      if (!arm)
      begin
        st <= CAPB_KEY_WAIT;
        idx <= 3'h0;
      end
      else
        case (st)
          CAPB_KEY_WAIT:
            if (len == `CAPB_WAKE_ANY)
              wake <= |touch_evt;
            else if (len != `CAPB_WAKE_NONE)
            begin
              if (hit)
                st <= CAPB_KEY_HELD;
              else if (|touch_evt)
                idx <= 3'h0;
            end
          CAPB_KEY_HELD:
            if (lifted)
            begin
              st <= CAPB_KEY_WAIT;
              idx <= last ? 3'h0 : 3'(idx + 3'h1);
              wake <= last;
            end
          default:
            st <= CAPB_KEY_WAIT;
        endcase
    end
  end
endmodule

// ==== hdl/capb_top.sv ====
`timescale 1ns/1ps
`include "capb_consts.svh"
// Functional notes
// - touch when ticks exceed threshold plus threshold times hysteresis
// - release when ticks fall below threshold minus its hysteresis share
// - one hysteresis percentage shared by all sensors
// - touch debounce starts on first sample above touch level
// - count consecutive qualifying samples, one per scan, before deciding
// - debounce code 00 acts at once, 01..11 need two to four
// - report all touches, or only the first until it is released
// - report code 00 multiple, 01 first-only, others reserved
// - interrupt on touches, releases or both as configured
// - interrupt code 00 masked, 01 touch, 10 release, 11 both
// - freeze averaging when the average reaches its level
// - averaging level scaled at four ticks per count
// - three or more frozen sensors at once start compensation
// - large negative ticks trigger offset compensation
// - negative counter counts low samples, triggers at its limit
// - held timeout forces compensation and a release
// - after forced release, report again once lifted and touched anew
// - held timeout of zero disables the timer
// - proximity sensors handled exactly like buttons
// - wake length 0 any touch, 1..6 ordered keys, 7 none
// - key counts only after its release; a wrong touch while waiting restarts the sequence
// - four-bit key codes select buttons 0..7, others reserved
module capb_top
  import capb_pkg::*;
#(
  parameter int unsigned SECOND_CYCLES = `CAPB_SECOND_S * `CAPB_CLK_HZ
)
(
  input logic clk, // 200 MHz clock
  input logic resetn, // async reset, low
  input logic [7:0] reg_addr, // register offset
  input logic [7:0] reg_wdata, // write data
  input logic reg_wr, // write strobe
  input logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data
  input logic sample_valid, // one per scan period
  input logic [127:0] ticks, // sensor i at [16i+:16]
  input logic [63:0] per_sensor_level, // sensor i at [8i+:8]
  input logic enter_doze, // host asks for doze
  input logic host_wake_cmd, // host asks for active
  input logic general_input_pin, // wake level, high
  input logic irq_ack, // host clears interrupt
  output logic [7:0] button_state, // reported touched
  output logic [7:0] button_touch_evt, // reported touches
  output logic [7:0] button_release_evt, // reported releases
  output logic [7:0] averaging_frozen, // per sensor freeze
  output logic offset_comp_start, // compensation request
  output logic in_doze, // doze mode
  output logic interrupt_n // event pending, low
);
  logic [7:0] button_policy_config;
  logic [7:0] average_freeze_level;
  logic [7:0] negative_comp_level;
  logic [7:0] negative_count_limit;
  logic [7:0] touch_hysteresis_pct;
  logic [7:0] held_touch_timeout;
  logic [2:0] wake_sequence_length;
  logic [7:0] wake_keys_five_four;
  logic [7:0] wake_keys_three_two;
  logic [7:0] wake_keys_one_zero;

  logic sel_cfg, sel_avg, sel_neg, sel_max, sel_hyst, sel_stuck;
  logic sel_len, sel_k54, sel_k32, sel_k10;
  logic [7:0] rd_mux;

  logic [7:0] raw_touch, raw_release, raw_state;
  logic [7:0] neg_hit, stuck_hit;
  logic [7:0] owner, first_touch, rep_touch, rep_release, next_owner;
  logic [1:0] rpt_mode, irq_mode;
  logic first_only, irq_hit, irq_pending;
  logic [3:0] frozen_count;
  logic many, many_q, comp_go, wake;
  logic [31:0] pre_cnt;
  logic sec_tick;
  capb_mode_t mode;

  capb_cfg_if cfg_bus ();

  // ========
  // register decode
  assign sel_cfg = reg_addr == `CAPB_A_BTN_CFG;
  assign sel_avg = reg_addr == `CAPB_A_AVG_LVL;
  assign sel_neg = reg_addr == `CAPB_A_NEG_LVL;
  assign sel_max = reg_addr == `CAPB_A_NEG_MAX;
  assign sel_hyst = reg_addr == `CAPB_A_HYST;
  assign sel_stuck = reg_addr == `CAPB_A_STUCK;
  assign sel_len = reg_addr == `CAPB_A_WAKE_LEN;
  assign sel_k54 = reg_addr == `CAPB_A_KEYS_54;
  assign sel_k32 = reg_addr == `CAPB_A_KEYS_32;
  assign sel_k10 = reg_addr == `CAPB_A_KEYS_10;

  // write side; reserved upper bits of the length are not stored
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      button_policy_config <= `CAPB_R_BTN_CFG;
      average_freeze_level <= `CAPB_R_AVG_LVL;
      negative_comp_level <= `CAPB_R_NEG_LVL;
      negative_count_limit <= `CAPB_R_NEG_MAX;
      touch_hysteresis_pct <= `CAPB_R_HYST;
      held_touch_timeout <= `CAPB_R_STUCK;
      wake_sequence_length <= `CAPB_R_WAKE_LEN;
      wake_keys_five_four <= `CAPB_R_KEYS;
      wake_keys_three_two <= `CAPB_R_KEYS;
      wake_keys_one_zero <= `CAPB_R_KEYS;
    end
    else if (reg_wr)
    begin
      if (sel_cfg)
        button_policy_config <= reg_wdata;
      if (sel_avg)
        average_freeze_level <= reg_wdata;
      if (sel_neg)
        negative_comp_level <= reg_wdata;
      if (sel_max)
        negative_count_limit <= reg_wdata;
      if (sel_hyst)
        touch_hysteresis_pct <= reg_wdata;
      if (sel_stuck)
        held_touch_timeout <= reg_wdata;
      if (sel_len)
        wake_sequence_length <= reg_wdata[`CAPB_WAKE_LEN_W-1:0];
      if (sel_k54)
        wake_keys_five_four <= reg_wdata;
      if (sel_k32)
        wake_keys_three_two <= reg_wdata;
      if (sel_k10)
        wake_keys_one_zero <= reg_wdata;
    end
  end

  // read side; unmapped offsets read zero
  assign rd_mux =
    sel_cfg ? button_policy_config :
    sel_avg ? average_freeze_level :
    sel_neg ? negative_comp_level :
    sel_max ? negative_count_limit :
    sel_hyst ? touch_hysteresis_pct :
    sel_stuck ? held_touch_timeout :
    sel_len ? 8'(wake_sequence_length) :
    sel_k54 ? wake_keys_five_four :
    sel_k32 ? wake_keys_three_two :
    sel_k10 ? wake_keys_one_zero : 8'h00;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_mux;
  end

  // ========
  // seconds prescaler for the held timeout
  assign sec_tick = pre_cnt == 32'(SECOND_CYCLES - 1);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pre_cnt <= 32'h0000_0000;
    else if (sec_tick)
      pre_cnt <= 32'h0000_0000;
    else
      pre_cnt <= 32'(pre_cnt + 32'h1);
  end

  // ========
  // settings shared by all channels
  assign cfg_bus.sample_valid = sample_valid;
  assign cfg_bus.sec_tick = sec_tick;
  assign cfg_bus.comp_clear = offset_comp_start;
  assign cfg_bus.touch_db = button_policy_config[`CAPB_F_TDB +: 2];
  assign cfg_bus.release_db = button_policy_config[`CAPB_F_RDB +: 2];
  assign cfg_bus.avg_level = average_freeze_level;
  assign cfg_bus.neg_level = negative_comp_level;
  assign cfg_bus.neg_limit = negative_count_limit;
  assign cfg_bus.hyst_pct = touch_hysteresis_pct;
  assign cfg_bus.stuck_secs = held_touch_timeout;

  // one decision channel per sensor, buttons and proximity alike
  for (genvar i = 0; i < `CAPB_NSENS; i++)
  begin : g_chan
    capb_chan u_chan (
      .clk(clk),
      .resetn(resetn),
      .cfg(cfg_bus),
      .ticks(capb_tick_t'(ticks[i*`CAPB_TW +: `CAPB_TW])),
      .level(per_sensor_level[i*8 +: 8]),
      .touch_evt(raw_touch[i]),
      .release_evt(raw_release[i]),
      .touched(raw_state[i]),
      .frozen(averaging_frozen[i]),
      .neg_trig(neg_hit[i]),
      .stuck_trig(stuck_hit[i])
    );
  end

  // ========
  // reporting policy; reserved codes fall back to multiple
  assign rpt_mode = button_policy_config[`CAPB_F_RPT +: 2];
  assign first_only = rpt_mode == `CAPB_RPT_FIRST;
  // lowest index wins when several touch in one cycle
  assign first_touch = 8'(raw_touch & 8'(~raw_touch + 8'h01));
  assign rep_touch = !first_only ? raw_touch :
    (owner == 8'h00) ? first_touch : 8'h00;
  assign rep_release = first_only ? (raw_release & owner) :
    raw_release;
  assign next_owner = !first_only ? 8'h00 :
    (owner == 8'h00) ? first_touch :
    ((raw_release & owner) != 8'h00) ? 8'h00 : owner;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      owner <= 8'h00;
      button_touch_evt <= 8'h00;
      button_release_evt <= 8'h00;
      button_state <= 8'h00;
    end
    else
    begin
      owner <= next_owner;
      button_touch_evt <= rep_touch;
      button_release_evt <= rep_release;
      button_state <= first_only ? (raw_state & next_owner) : raw_state;
    end
  end

  // ========
  // interrupt; a new event wins over the acknowledge
  assign irq_mode = button_policy_config[`CAPB_F_IRQ +: 2];
  assign irq_hit = (irq_mode[`CAPB_IRQ_TOUCH] && |rep_touch) ||
    (irq_mode[`CAPB_IRQ_RELEASE] && |rep_release);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq_pending <= 1'b0;
    else
      irq_pending <= irq_hit || (irq_pending && !irq_ack);
  end
  assign interrupt_n = !irq_pending;

  // ========
  // compensation triggers
  always_comb
  begin
    frozen_count = 4'h0;
    for (int j = 0; j < `CAPB_NSENS; j++)
      frozen_count = 4'(frozen_count + 4'(averaging_frozen[j]));
  end
  assign many = frozen_count >= `CAPB_COMP_SENSORS;
  // only the onset counts, or a held group would retrigger forever
  assign comp_go = (many && !many_q) || |neg_hit || |stuck_hit;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      many_q <= 1'b0;
      offset_comp_start <= 1'b0;
    end
    else
    begin
      many_q <= many;
      offset_comp_start <= comp_go;
    end
  end

  // ========
  // doze and wake
  capb_wake u_wake (
    .clk(clk),
    .resetn(resetn),
    .arm(mode == CAPB_DOZE),
    .len(wake_sequence_length),
    .keys({wake_keys_five_four, wake_keys_three_two, wake_keys_one_zero}),
    .touch_evt(raw_touch),
    .release_evt(raw_release),
    .wake(wake)
  );

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      mode <= CAPB_ACTIVE;
    else
      case (mode)
        CAPB_ACTIVE:
          if (enter_doze)
            mode <= CAPB_DOZE;
        CAPB_DOZE:
          if (wake || host_wake_cmd || general_input_pin)
            mode <= CAPB_ACTIVE;
        default:
          mode <= CAPB_ACTIVE;
      endcase
  end
  assign in_doze = mode == CAPB_DOZE;
endmodule

// ==== testbench/capb_properties.sv ====
`timescale 1ns/1ps
`include "capb_consts.svh"
// ========
// port checker
module capb_properties
(
  input wire logic clk, // clock
  input wire logic resetn, // reset
  input wire logic [7:0] reg_addr, // offset
  input wire logic [7:0] reg_wdata, // data
  input wire logic reg_wr, // write
  input wire logic reg_rd, // read
  input wire logic [7:0] reg_rdata, // read data
  input wire logic enter_doze, // doze
  input wire logic host_wake_cmd, // wake
  input wire logic general_input_pin, // wake
  input wire logic irq_ack, // ack
  input wire logic [7:0] button_state, // state
  input wire logic [7:0] button_touch_evt, // touch
  input wire logic [7:0] button_release_evt, // release
  input wire logic [7:0] averaging_frozen, // frozen
  input wire logic offset_comp_start, // comp
  input wire logic in_doze, // doze
  input wire logic interrupt_n // irq
);
  logic [7:0] cfg;
  // policy copy, a write acts next cycle like in the block
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      cfg <= `CAPB_R_BTN_CFG;
    else if (reg_wr && reg_addr == `CAPB_A_BTN_CFG)
      cfg <= reg_wdata;
  // interrupt causes and three or more frozen sensors
  wire cause = (|button_touch_evt && cfg[4]) ||
    (|button_release_evt && cfg[5]);
  wire many = $countones(averaging_frozen) > 2;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  touch_state_a:
    assert property ((button_touch_evt & ~button_state) == 8'h00)
    else $error("touch without state");
  release_state_a:
    assert property ((button_release_evt & button_state) == 8'h00)
    else $error("release with state");
  touch_pulse_a:
    assert property ((button_touch_evt & $past(button_touch_evt)) == 8'h00)
    else $error("touch pulse too long");
  irq_raise_a:
    assert property (cause |-> !interrupt_n)
    else $error("irq not raised");
  irq_cause_a:
    assert property ($fell(interrupt_n) |-> cause)
    else $error("irq without cause");
  irq_clear_a:
    assert property (irq_ack ##1 !cause |-> interrupt_n)
    else $error("irq not cleared");
  comp_many_a:
    assert property ($rose(many) |=> offset_comp_start)
    else $error("no comp on frozen");
  doze_in_a:
    assert property (enter_doze && !host_wake_cmd && !general_input_pin
      |=> in_doze)
    else $error("no doze");
  wake_host_a:
    assert property (in_doze && host_wake_cmd && !enter_doze
      |=> ##[0:2] !in_doze)
    else $error("host wake lost");
  len_read_a:
    assert property (reg_rd && reg_addr == `CAPB_A_WAKE_LEN
      |=> reg_rdata[7:3] == 5'h00)
    else $error("length spare bits set");
endmodule

// ==== testbench/capb_host.sv ====
`timescale 1ns/1ps
// ========
// host side of the register port
module capb_host
(
  input wire logic clk, // clock
  input wire logic [7:0] reg_rdata, // read data
  output logic [7:0] reg_addr, // offset
  output logic [7:0] reg_wdata, // data
  output logic reg_wr, // write
  output logic reg_rd, // read
  output logic irq_ack // clear irq
);
  // idle bus at time zero
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, irq_ack} = '0;
  end
  // one write; data inverted after so no stale value lingers
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // one read, data taken after the loading edge
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task ack;
    @(posedge clk);
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
  endtask
  // software keeps the negative limit at one
  task init;
    wr(8'h24, 8'h01);
  endtask
endmodule

// ==== testbench/test_cap_button_decision_wakeup.sv ====
`timescale 1ns/1ps
`include "capb_consts.svh"
module test_cap_button_decision_wakeup;
  logic clk, resetn, sample_valid, enter_doze, host_wake_cmd, irq_ack;
  logic general_input_pin, reg_wr, reg_rd, in_doze, interrupt_n;
  logic offset_comp_start;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, button_state, g, at, ar;
  logic [7:0] button_touch_evt, button_release_evt, averaging_frozen;
  logic [127:0] ticks, v;
  logic [63:0] per_sensor_level;
  logic [1:0] q;
  int n_mismatch, checks_done, nc, c0, p, nl;
  int lv [8];
  logic [7:0] ws [12] = '{8'h20, 8'h24, 8'h20, 8'h00, 8'h80, 8'h00,
    8'h04, 8'h00, 8'h20, 8'h00, 8'h04, 8'h00};
  logic [7:0] ra [4] = '{8'h21, 8'h24, 8'h26, 8'h40};
  logic [7:0] rv [4] = '{8'h30, 8'h01, 8'h00, 8'h00};
  localparam logic [15:0] HI = 16'h0800;
  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  capb_top #(.SECOND_CYCLES(20)) dut (.*);
  capb_host host (.*);
  // event collectors, emptied at falling edges
  always @(posedge clk)
  begin
    at = at | button_touch_evt;
    ar = ar | button_release_evt;
    nc = nc + int'(offset_comp_start);
  end
  // touch and release levels with shared hysteresis
  function int up(int l);
    return l * 4 * (100 + p) / 100 + 1;
  endfunction
  function int dn(int l);
    return (l * 4 * (100 - p) - 1) / 100;
  endfunction
  function logic [127:0] fv(logic [7:0] m);
    for (int i = 0; i < 8; i++)
      fv[16*i+:16] = m[i] ? HI : 16'h0000;
  endfunction
  task chk(string n, logic [7:0] e, logic [7:0] s);
    checks_done++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task samp(logic [127:0] t);
    @(posedge clk);
    ticks <= t;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task ev(logic [7:0] et, logic [7:0] er);
    @(negedge clk);
    chk("touch", et, at);
    chk("release", er, ar);
    at = 8'h00;
    ar = 8'h00;
  endtask
  task hy(int d, bit u, logic [7:0] et, logic [7:0] er);
    for (int i = 0; i < 8; i++)
      v[16*i+:16] = 16'(u ? up(lv[i]) + d : dn(lv[i]) + d);
    samp(v);
    ev(et, er);
  endtask
  task cmd(int k);
    @(posedge clk);
    {general_input_pin, host_wake_cmd, enter_doze} <= 3'(1 << k);
    @(posedge clk);
    {general_input_pin, host_wake_cmd, enter_doze} <= 3'h0;
    repeat (3) @(posedge clk);
  endtask
  task dz(logic e);
    @(negedge clk);
    chk("doze", 8'(e), 8'(in_doze));
  endtask
  task ir(logic e);
    @(negedge clk);
    chk("irq", 8'(e), 8'(interrupt_n));
    host.ack;
  endtask
  task comp(int e);
    @(negedge clk);
    chk("comp", 8'(e), 8'(nc - c0));
  endtask
  task test_done;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog, far beyond the roughly one thousand cycles needed
  initial
  begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    test_done;
  end
  // main sequence
  initial
  begin
    {resetn, sample_valid, enter_doze, host_wake_cmd} = 4'h0;
    general_input_pin = 1'b0;
    ticks = '0;
    {at, ar, nc, n_mismatch, checks_done} = '0;
    void'($urandom(32'ha6ba));
    p = $urandom % 100;
    for (int i = 0; i < 8; i++)
    begin
      lv[i] = 10 + $urandom % 21;
      per_sensor_level[8*i+:8] = 8'(lv[i]);
    end
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    foreach (ra[i])
    begin
      host.rd(ra[i], g);
      chk("reg", rv[i], g);
    end
    host.wr(8'h33, 8'hff);
    host.rd(8'h33, g);
    chk("len", 8'h07, g);
    host.init;
    host.wr(`CAPB_A_HYST, 8'(p));
    hy(-1, 1, 8'h00, 8'h00);
    hy(0, 1, 8'hff, 8'h00);
    hy(1, 0, 8'h00, 8'h00);
    hy(0, 0, 8'h00, 8'hff);
    $display("test levels done");
    for (int k = 0; k < 4; k++)
    begin
      q = 2'(k);
      host.wr(`CAPB_A_BTN_CFG, {4'h3, q, q});
      repeat (k) samp(fv(8'h01));
      samp('0);
      repeat (k) samp(fv(8'h01));
      ev(8'h00, 8'h00);
      samp(fv(8'h01));
      ev(8'h01, 8'h00);
      repeat (k) samp('0);
      samp(fv(8'h01));
      repeat (k) samp('0);
      ev(8'h00, 8'h00);
      samp('0);
      ev(8'h00, 8'h01);
    end
    $display("test debounce done");
    for (int k = 0; k < 4; k++)
    begin
      q = 2'(k);
      g = (k == 1) ? 8'h02 : 8'h06;
      host.wr(`CAPB_A_BTN_CFG, {q, 6'h30});
      samp(fv(8'h02));
      samp(fv(8'h06));
      ev(g, 8'h00);
      samp(fv(8'h04));
      samp('0);
      ev(8'h00, g);
    end
    $display("test policy done");
    for (int k = 0; k < 4; k++)
    begin
      q = 2'(k);
      host.wr(`CAPB_A_BTN_CFG, {2'h0, q, 4'h0});
      host.ack;
      samp(fv(8'h01));
      ir(!q[0]);
      samp('0);
      ir(!q[1]);
    end
    ev(8'h01, 8'h01);
    $display("test irq done");
    nl = 1 + $urandom % 50;
    host.wr(`CAPB_A_NEG_LVL, 8'(nl));
    host.wr(`CAPB_A_NEG_MAX, 8'h02);
    c0 = nc;
    for (int k = 0; k < 5; k++)
      samp({8{16'(-4 * nl - k % 2)}});
    comp(0);
    repeat (2) samp({8{16'(-4 * nl - 1)}});
    comp(1);
    host.init;
    samp({8{16'(-4 * nl - 1)}});
    comp(2);
    $display("test negative done");
    host.wr(`CAPB_A_AVG_LVL, 8'h01);
    c0 = nc;
    samp({80'h0, 16'd31, 16'd32, 16'd32});
    @(negedge clk);
    chk("frozen", 8'h03, averaging_frozen);
    samp({80'h0, 16'd31, 16'd32, 16'd32});
    comp(1);
    host.wr(`CAPB_A_AVG_LVL, 8'h50);
    $display("test average done");
    host.wr(`CAPB_A_STUCK, 8'h02);
    c0 = nc;
    samp(fv(8'h08));
    ev(8'h08, 8'h00);
    repeat (60) @(posedge clk);
    ev(8'h00, 8'h08);
    comp(1);
    samp(fv(8'h08));
    ev(8'h00, 8'h00);
    samp('0);
    samp(fv(8'h08));
    ev(8'h08, 8'h00);
    host.wr(`CAPB_A_STUCK, 8'h00);
    repeat (100) @(posedge clk);
    ev(8'h00, 8'h00);
    samp('0);
    $display("test held done");
    host.wr(`CAPB_A_WAKE_LEN, 8'h00);
    cmd(0);
    samp(fv(8'h01));
    dz(1'b0);
    samp('0);
    host.wr(`CAPB_A_KEYS_10, 8'h25);
    host.wr(`CAPB_A_WAKE_LEN, 8'h02);
    cmd(0);
    foreach (ws[i])
    begin
      samp(fv(ws[i]));
      dz(i < 11);
    end
    host.wr(`CAPB_A_WAKE_LEN, 8'h07);
    cmd(0);
    samp(fv(8'h01));
    samp('0);
    dz(1'b1);
    cmd(1);
    dz(1'b0);
    cmd(0);
    cmd(2);
    dz(1'b0);
    host.wr(`CAPB_A_KEYS_10, 8'h08);
    host.wr(`CAPB_A_WAKE_LEN, 8'h01);
    cmd(0);
    samp(fv(8'hff));
    samp('0);
    dz(1'b1);
    cmd(1);
    $display("test wake done");
    test_done;
  end
endmodule
bind capb_top capb_properties props (.*);
